// *** vector_place.sv ***
// Reset and interrupt vector address generator with boot placement.
// Assumes requests and reset pulses come from logic on core_clk; the fuse is a pin.
`timescale 1ns/1ps
`include "vector_place_consts.svh"

module vector_place
  import vector_place_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [11:0] BOOT_ADDR = `BOOT_ADDR_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Reset sources, one-cycle pulses
  input wire logic pin_reset_req,
  input wire logic brownout_reset_req,
  input wire logic watchdog_reset_req,
  // Boot fuse pin
  input wire logic boot_reset_fuse,
  // Control register write port from the core
  input wire logic gic_wr_en,
  input wire logic [1:0] gic_wr_data,
  // Interrupt requests, levels
  input wire logic ext_request_zero,
  input wire logic ext_request_one,
  input wire logic timer_two_compare_irq,
  input wire logic timer_two_overflow_irq,
  input wire logic timer_one_capture_irq,
  input wire logic timer_one_match_a_irq,
  input wire logic timer_one_match_b_irq,
  input wire logic timer_one_overflow_irq,
  input wire logic timer_zero_overflow_irq,
  input wire logic serial_transfer_done_irq,
  input wire logic receive_complete_irq,
  input wire logic transmit_buffer_empty_irq,
  input wire logic transmit_complete_irq,
  input wire logic conv_done_irq,
  input wire logic eeprom_ready_irq,
  input wire logic comparator_irq,
  input wire logic two_wire_irq,
  input wire logic selfprog_ready_irq,
  // Core accepts an interrupt this cycle
  input wire logic irq_take,
  // Fetch answer to the core
  output logic fetch_valid_reg,
  output logic fetch_is_reset_reg,
  output logic [ADDR_W-1:0] fetch_addr_reg,
  output logic [4:0] fetch_vec_reg,
  output logic [`IRQ_COUNT-1:0] irq_ack_reg,
  // Control register readback
  output logic [1:0] general_irq_control_reg
);

  // ========================================
  // Functions
  // Table offset of request index i
  function automatic logic [11:0] offset_of(input logic [4:0] i);
    logic [11:0] o;
    o = `RESET_OFS;
    case (i)
      5'h00: o = `OFS_EXT_ZERO;
      5'h01: o = `OFS_EXT_ONE;
      5'h02: o = `OFS_T2_CMP;
      5'h03: o = `OFS_T2_OVF;
      5'h04: o = `OFS_T1_CAPT;
      5'h05: o = `OFS_T1_MA;
      5'h06: o = `OFS_T1_MB;
      5'h07: o = `OFS_T1_OVF;
      5'h08: o = `OFS_T0_OVF;
      5'h09: o = `OFS_SERIAL;
      5'h0a: o = `OFS_RX;
      5'h0b: o = `OFS_TX_EMPTY;
      5'h0c: o = `OFS_TX_DONE;
      5'h0d: o = `OFS_CONV;
      5'h0e: o = `OFS_EEPROM;
      5'h0f: o = `OFS_COMP;
      5'h10: o = `OFS_TWO_WIRE;
      5'h11: o = `OFS_SELFPROG;
      default: o = `RESET_OFS;
    endcase
    return o;
  endfunction

  // Lowest pending index, table order
  function automatic logic [4:0] first_pending(input logic [`IRQ_COUNT-1:0] p);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = `IRQ_COUNT - 1; k >= 0; k--) begin
      if (p[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  // ========================================
  // Declarations
  seq_state_t state_reg, state_next;
  logic fuse_meta_reg, fuse_sync_reg, fuse_cap_reg;
  logic [2:0] ce_cnt_reg;
  logic [1:0] settle_cnt_reg;
  wire [`IRQ_COUNT-1:0] pend;
  wire any_reset;
  wire any_pend;
  wire [4:0] pick;
  wire [11:0] reset_origin;
  wire [11:0] table_origin;
  wire [11:0] irq_addr;
  wire accept;
  wire ce_open;

  // Request gathering
  assign pend = {selfprog_ready_irq, two_wire_irq, comparator_irq, eeprom_ready_irq,
                 conv_done_irq, transmit_complete_irq, transmit_buffer_empty_irq,
                 receive_complete_irq, serial_transfer_done_irq, timer_zero_overflow_irq,
                 timer_one_overflow_irq, timer_one_match_b_irq, timer_one_match_a_irq,
                 timer_one_capture_irq, timer_two_overflow_irq, timer_two_compare_irq,
                 ext_request_one, ext_request_zero};
  assign any_reset = pin_reset_req | brownout_reset_req | watchdog_reset_req;
  assign any_pend = |pend;
  assign pick = first_pending(pend);
  assign accept = (state_reg == ST_RUN) && irq_take && any_pend && !any_reset;

  // Placement selection, fuse and select bit independent
  assign reset_origin = (fuse_cap_reg == `FUSE_UNPROG) ? `RESET_OFS : BOOT_ADDR;
  assign table_origin = general_irq_control_reg[`SEL_BIT] ? BOOT_ADDR : `RESET_OFS;
  assign irq_addr = table_origin + offset_of(pick);
  assign ce_open = (ce_cnt_reg != 3'h0);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SETTLE: state_next = (settle_cnt_reg == 2'h3) ? ST_RESET : ST_SETTLE;
      ST_RESET: state_next = ST_RUN;
      ST_RUN: state_next = any_reset ? ST_SETTLE : ST_RUN;
    endcase
  end

  // Fuse pin synchroniser
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_meta_reg <= `FUSE_UNPROG;
      fuse_sync_reg <= `FUSE_UNPROG;
    end else begin
      fuse_meta_reg <= boot_reset_fuse;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // Sequencer, settle count and fuse capture after release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_SETTLE;
      settle_cnt_reg <= 2'h0;
      fuse_cap_reg <= `FUSE_UNPROG;
    end else begin
      state_reg <= state_next;
      settle_cnt_reg <= (state_reg == ST_SETTLE) ? settle_cnt_reg + 2'h1 : 2'h0;
      if (state_reg == ST_SETTLE) begin
        fuse_cap_reg <= fuse_sync_reg;
      end
    end
  end

  // Control register with timed change enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      general_irq_control_reg <= `GIC_RESET;
      ce_cnt_reg <= 3'h0;
    end else if (state_reg != ST_RUN || any_reset) begin
      general_irq_control_reg <= `GIC_RESET;
      ce_cnt_reg <= 3'h0;
    end else if (gic_wr_en && gic_wr_data[`CE_BIT]) begin
      general_irq_control_reg[`CE_BIT] <= 1'b1;
      ce_cnt_reg <= `CE_WINDOW;
    end else if (gic_wr_en && ce_open) begin
      general_irq_control_reg <= {gic_wr_data[`SEL_BIT], 1'b0};
      ce_cnt_reg <= 3'h0;
    end else begin
      ce_cnt_reg <= ce_open ? ce_cnt_reg - 3'h1 : 3'h0;
      if (ce_cnt_reg == 3'h1) begin
        general_irq_control_reg[`CE_BIT] <= 1'b0;
      end
    end
  end

  // Fetch answer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_valid_reg <= 1'b0;
      fetch_is_reset_reg <= 1'b0;
      fetch_addr_reg <= '0;
      fetch_vec_reg <= 5'h00;
      irq_ack_reg <= '0;
    end else begin
      fetch_valid_reg <= (state_reg == ST_RESET) || accept;
      fetch_is_reset_reg <= (state_reg == ST_RESET);
      irq_ack_reg <= accept ? (`IRQ_COUNT'(1) << pick) : '0;
      if (state_reg == ST_RESET) begin
        fetch_addr_reg <= ADDR_W'(reset_origin);
        fetch_vec_reg <= 5'h01;
      end else if (accept) begin
        fetch_addr_reg <= ADDR_W'(irq_addr);
        fetch_vec_reg <= pick + 5'h02;
      end
    end
  end

  // ========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  reset_entry_a: assert property (
    state_reg == ST_RESET |=> fetch_valid_reg && fetch_is_reset_reg
    && fetch_addr_reg == ADDR_W'($past(reset_origin))) else $error("bad reset entry");
  vector_range_a: assert property (
    fetch_valid_reg |-> fetch_vec_reg >= 5'h01 && fetch_vec_reg <= 5'h13)
    else $error("vector out of table");
  ext_zero_a: assert property (
    accept && ext_request_zero |=> fetch_addr_reg == ADDR_W'($past(table_origin) + 12'h001))
    else $error("ext zero slot");
  timer_one_a: assert property (
    accept && pend[3:0] == 4'h0 && pend[4] |=> fetch_addr_reg
    == ADDR_W'($past(table_origin) + 12'h005)) else $error("timer one slot");
  serial_slot_a: assert property (
    accept && pick == 5'h09 |=> fetch_vec_reg == 5'h0b) else $error("serial slot");
  usart_slot_a: assert property (
    accept && pick == 5'h0a |=> fetch_addr_reg == ADDR_W'($past(table_origin) + 12'h00b))
    else $error("usart slot");
  two_wire_a: assert property (
    accept && pick == 5'h10 |=> fetch_vec_reg == 5'h12) else $error("two-wire slot");
  last_slot_a: assert property (
    accept && pend == 18'h20000 |=> fetch_addr_reg == ADDR_W'($past(table_origin) + 12'h012)
    && irq_ack_reg[17]) else $error("last slot");
  boot_start_a: assert property (
    state_reg == ST_RESET && fuse_cap_reg == 1'b0 |=> fetch_addr_reg == ADDR_W'(BOOT_ADDR))
    else $error("boot start");
  // Shifted table: boot start plus the entry's default slot, vector number minus one
  table_shift_a: assert property (
    accept && general_irq_control_reg[`SEL_BIT] |=> fetch_addr_reg
    == ADDR_W'(BOOT_ADDR + 12'(fetch_vec_reg) - 12'h001)) else $error("table shift");
  ce_timeout_a: assert property (
    gic_wr_en && gic_wr_data == 2'h1 && state_reg == ST_RUN && !any_reset
    |=> ##4 !general_irq_control_reg[`CE_BIT]) else $error("ce timeout");
  entry_calc_a: assert property (
    accept |=> fetch_addr_reg == ADDR_W'($past(table_origin) + 12'(fetch_vec_reg) - 12'h001))
    else $error("entry calc");

  reset_fetch_c: cover property (state_reg == ST_RESET ##1 fetch_valid_reg);
  boot_table_c: cover property (accept && general_irq_control_reg[`SEL_BIT]);
  irq_fetch_c: cover property (accept ##1 fetch_valid_reg && !fetch_is_reset_reg);
  boot_reset_c: cover property (state_reg == ST_RESET && fuse_cap_reg == 1'b0);

endmodule

// *** vector_place_consts.svh ***
// Constants for reset and interrupt vector placement.
// Assumes a word-addressed program store and a core that fetches the issued address.
//
// Contract
// - Any reset source restarts at reset entry.
// - Nineteen consecutive one-word entries, fixed order.
// - External requests zero/one at 0x001, 0x002.
// - Timer one capture/A/B/overflow at 0x005..0x008.
// - Serial transfer done at 0x00a.
// - USART receive/empty/transmit at 0x00b..0x00d.
// - Converter, EEPROM, comparator, two-wire at 0x00e..0x011.
// - Self-programming ready is last, 0x012.
// - Programmed boot fuse starts at boot address.
// - Select bit adds boot start to entries.
// - Reset and table placement chosen independently.
// - Fuse value one unprogrammed, zero programmed.
// - Select bit 1, change enable bit 0.
`ifndef VECTOR_PLACE_CONSTS_SVH
`define VECTOR_PLACE_CONSTS_SVH

// ========================================
// Table layout
`define RESET_OFS 12'h000
`define OFS_EXT_ZERO 12'h001
`define OFS_EXT_ONE 12'h002
`define OFS_T2_CMP 12'h003
`define OFS_T2_OVF 12'h004
`define OFS_T1_CAPT 12'h005
`define OFS_T1_MA 12'h006
`define OFS_T1_MB 12'h007
`define OFS_T1_OVF 12'h008
`define OFS_T0_OVF 12'h009
`define OFS_SERIAL 12'h00a
`define OFS_RX 12'h00b
`define OFS_TX_EMPTY 12'h00c
`define OFS_TX_DONE 12'h00d
`define OFS_CONV 12'h00e
`define OFS_EEPROM 12'h00f
`define OFS_COMP 12'h010
`define OFS_TWO_WIRE 12'h011
`define OFS_SELFPROG 12'h012
`define IRQ_COUNT 18

// ========================================
// Control register fields and timing
`define SEL_BIT 1
`define CE_BIT 0
`define GIC_RESET 2'h0
`define FUSE_UNPROG 1'h1
`define CE_WINDOW 3'h4
`define BOOT_ADDR_DEF 12'hc00

`endif

// *** vector_place_pkg.sv ***
// Types for reset and interrupt vector placement.
// Assumes vector_place_consts.svh supplies the numbers.
package vector_place_pkg;
  // ========================================
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_RESET = 3'h2,
    ST_RUN = 3'h4
  } seq_state_t;
endpackage

// *** core_model.sv ***
// Core model: accepts interrupts at one of two fixed paces, chosen by slow, and counts issued fetches.
// Assumes the vector block answers on core_clk.
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pace select and fetch port
  input wire logic slow,
  input wire logic fetch_valid_reg,
  output logic irq_take,
  output logic [7:0] fetch_cnt
);
  logic [3:0] gap_reg;
  // ==========
  // One-cycle accept pulse per gap; code runs only from issued fetches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 4'h0;
      fetch_cnt <= 8'h0;
    end else begin
      gap_reg <= (gap_reg >= (slow ? 4'h8 : 4'h3)) ? 4'h0 : gap_reg + 4'h1;
      fetch_cnt <= fetch_cnt + {7'h0, fetch_valid_reg};
    end
  end
  assign irq_take = (gap_reg == 4'h0);
endmodule

// *** reset_irq_vector_placement_test.sv ***
// Testbench for the vector placement block.
// Assumes the core model in core_model.sv and the design's constants header.
`timescale 1ns/1ps
`include "vector_place_consts.svh"
module reset_irq_vector_placement_test;
  import vector_place_pkg::*;
  localparam logic [11:0] boot = `BOOT_ADDR_DEF;
  logic core_clk, rst_b, pin_q, bod_q, wdt_q, fuse, wr_en, slow, take, valid, is_rst;
  logic [1:0] wr_data, gic;
  logic [17:0] irq, ack, got;
  logic [11:0] addr;
  logic [4:0] vec;
  logic [7:0] fcnt;
  int n_fail, n_compared, cyc;
  // ==========
  // Design and core model
  vector_place uut (.core_clk(core_clk), .rst_b(rst_b), .pin_reset_req(pin_q),
    .brownout_reset_req(bod_q), .watchdog_reset_req(wdt_q), .boot_reset_fuse(fuse),
    .gic_wr_en(wr_en), .gic_wr_data(wr_data), .ext_request_zero(irq[0]),
    .ext_request_one(irq[1]), .timer_two_compare_irq(irq[2]),
    .timer_two_overflow_irq(irq[3]), .timer_one_capture_irq(irq[4]),
    .timer_one_match_a_irq(irq[5]), .timer_one_match_b_irq(irq[6]),
    .timer_one_overflow_irq(irq[7]), .timer_zero_overflow_irq(irq[8]),
    .serial_transfer_done_irq(irq[9]), .receive_complete_irq(irq[10]),
    .transmit_buffer_empty_irq(irq[11]), .transmit_complete_irq(irq[12]),
    .conv_done_irq(irq[13]), .eeprom_ready_irq(irq[14]), .comparator_irq(irq[15]),
    .two_wire_irq(irq[16]), .selfprog_ready_irq(irq[17]), .irq_take(take),
    .fetch_valid_reg(valid), .fetch_is_reset_reg(is_rst), .fetch_addr_reg(addr),
    .fetch_vec_reg(vec), .irq_ack_reg(ack), .general_irq_control_reg(gic));
  core_model core (.core_clk(core_clk), .rst_b(rst_b), .slow(slow),
    .fetch_valid_reg(valid), .irq_take(take), .fetch_cnt(fcnt));
  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_fetch();
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1;
      cyc++;
    end while (valid !== 1'b1 && cyc < 40);
    check(valid, 1, "fetch seen");
  endtask
  task automatic fire(input logic [17:0] raise, input int idx, input logic [11:0] base);
    @(posedge core_clk);
    irq <= irq | raise;
    wait_fetch();
    check(is_rst, 0, "reset flag");
    check(addr, base + idx + 1, "address");
    check(vec, idx + 2, "number");
    check(ack, 32'h1 << idx, "ack");
    got = ack;
    @(posedge core_clk);
    irq <= irq & ~got;
  endtask
  task automatic gic_write(input logic [1:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic src_reset(input int which, input logic f, input logic [11:0] exp);
    @(posedge core_clk);
    fuse <= f;
    repeat (3) @(posedge core_clk);
    pin_q <= (which == 0);
    bod_q <= (which == 1);
    wdt_q <= (which == 2);
    @(posedge core_clk);
    {pin_q, bod_q, wdt_q} <= 3'h0;
    wait_fetch();
    check(is_rst, 1, "src reset flag");
    check(addr, exp, "src reset address");
    check(gic, 0, "select after reset");
  endtask
  // ==========
  // Scenarios
  task automatic test_power_on();
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_fetch();
    check(cyc, 5, "settle");
    check(is_rst, 1, "reset flag");
    check(addr, 0, "reset address");
    check(vec, 1, "reset number");
    fire(0, 0, 0);
  endtask
  task automatic test_refuse();
    // Let the count of the last fetch settle before taking it as reference
    #1;
    cyc = fcnt;
    repeat (12) @(posedge core_clk);
    #1;
    check(fcnt, cyc, "idle take");
  endtask
  task automatic test_table(input logic [11:0] base);
    for (int i = 0; i < `IRQ_COUNT; i++) begin
      fire(18'h1 << i, i, base);
    end
    fire(18'h0000a, 1, base);
    fire(0, 3, base);
  endtask
  task automatic test_select();
    gic_write(2'h1);
    repeat (6) @(posedge core_clk);
    #1;
    check(gic, 0, "enable clears");
    gic_write(2'h2);
    repeat (2) @(posedge core_clk);
    #1;
    check(gic, 0, "late write");
    gic_write(2'h1);
    gic_write(2'h2);
    repeat (2) @(posedge core_clk);
    #1;
    check(gic, 2, "select set");
    test_table(boot);
  endtask
  task automatic test_sources();
    src_reset(0, 1'b0, boot);
    fire(18'h10, 4, 0);
    gic_write(2'h1);
    gic_write(2'h2);
    fire(18'h20000, 17, boot);
    src_reset(1, 1'b1, 0);
    src_reset(2, 1'b0, boot);
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst_b, pin_q, bod_q, wdt_q, wr_en, slow} = 6'h0;
    fuse = 1'b1;
    wr_data = 2'h0;
    irq = 18'h1;
    test_power_on();
    test_refuse();
    test_table(0);
    slow <= 1'b1;
    test_select();
    slow <= 1'b0;
    test_sources();
    print_verdict();
  end
endmodule
